//--- hdl/peripheral_bus_bridge.sv
// bridge from the main bus to peripheral buses 1..6 and the external bus unit
// Functional notes
// - total is main plus sync plus peripheral cycles
// - sync cycles on every bus except bus one, the external bus included
// - sync length follows clock ratio and phase
// - main plus sync within one target cycle
// - faster target counts in core clock cycles
// - external access main plus sync within one cycle
// - collisions with other masters lengthen the access
// - pin function bytes take two target cycles
`timescale 1ns/1ns
`include "bridge_map.svh"
module peripheral_bus_bridge #(
   parameter int DIV_W = 4
) (
   // clock and reset
   input  wire logic                      clk_in,
   input  wire logic                      arst_n_in,
   // clock ratios of the divided clocks against the core clock
   input  wire logic [DIV_W-1:0]          periph_div_in,
   input  wire logic [DIV_W-1:0]          flash_div_in,
   input  wire logic [DIV_W-1:0]          extbus_div_in,
   // master side
   input  wire bridge_pkg::master_req_type req_in,
   input  wire logic                      conflict_in,
   output logic                           stall_out,
   output logic                           ack_out,
   output logic [31:0]                    rdata_out,
   // peripheral side
   output bridge_pkg::periph_req_type     per_req_out,
   input  wire logic [31:0]               per_rdata_in
);
   import bridge_pkg::*;

   bridge_state_type state;        // sequencer state
   bridge_state_type next_state;   // state for the next cycle
   master_req_type   held;         // request captured at acceptance
   logic [3:0]       remain;       // peripheral bus cycles still to run
   logic [3:0]       next_remain;  // remain for the next cycle
   logic [DIV_W-1:0] sel_div;      // ratio of the selected target clock
   logic             sel_tick;     // edge tick of the selected target clock

   wire  tick_periph;              // peripheral clock edge
   wire  tick_flash;               // flash interface clock edge
   wire  tick_extbus;              // external bus clock edge
   wire  take;                     // a new request is accepted
   wire  target_slow;              // core faster than the target
   wire  needs_sync;               // access goes through a sync stage
   wire  pin_func_byte;            // byte access to a pin function register
   wire  peri_tick;                // one peripheral bus cycle elapses
   wire  [3:0] load_cycles;        // peripheral bus cycles for this access

   // one ticker per divided clock
   clock_phase_tick #(.DIV_W(DIV_W)) periph_ticker (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .div_in    (periph_div_in),
      .tick_out  (tick_periph)
   );
   clock_phase_tick #(.DIV_W(DIV_W)) flash_ticker (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .div_in    (flash_div_in),
      .tick_out  (tick_flash)
   );
   clock_phase_tick #(.DIV_W(DIV_W)) extbus_ticker (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .div_in    (extbus_div_in),
      .tick_out  (tick_extbus)
   );

   // pick ratio and tick of the target clock; external unit always uses its bus clock
   always_comb
   begin
      sel_div  = periph_div_in;
      sel_tick = tick_periph;
      if (held.bus_num == `EXT_BUS || held.tgt_clk == TGT_EXTBUS)
      begin
         sel_div  = extbus_div_in;
         sel_tick = tick_extbus;
      end
      else if (held.tgt_clk == TGT_FLASH)
      begin
         sel_div  = flash_div_in;
         sel_tick = tick_flash;
      end
   end

   // the answer cycle takes a waiting request as well, so the next access
   // starts in the core cycle right after the finished one
   assign take          = ((state == ST_IDLE) || (state == ST_DONE)) && req_in.valid;
   // ratio 0 or 1 means the core is not faster; counted in core cycles then
   assign target_slow   = (sel_div > {{(DIV_W-1){1'b0}}, 1'b1});
   // bus one shares the core clock, so it never takes the sync wait for a divided edge
   assign needs_sync    = (held.bus_num != `SYNC_FREE_BUS) && target_slow;
   // slow targets advance per target edge, fast ones per core cycle
   assign peri_tick     = target_slow ? sel_tick : 1'b1;
   assign pin_func_byte = (req_in.addr >= `PIN_FUNC_LOW)
                       && (req_in.addr <= `PIN_FUNC_HIGH)
                       && (req_in.size == SIZE_BYTE);
   // per register count, fixed for pin function bytes; zero is taken as one
   assign load_cycles   = pin_func_byte ? `PIN_FUNC_CYCLES
                        : (req_in.bus_cycles == 4'h0) ? 4'h1 : req_in.bus_cycles;

   // sequencer: main bus cycle, optional sync wait, peripheral cycles, answer
   always_comb
   begin
      next_state  = state;
      next_remain = remain;
      case (state)
         ST_IDLE:
         begin
            if (take)
            begin
               next_state  = ST_MAIN;
               next_remain = load_cycles;
            end
         end
         ST_MAIN:
         begin
            // another master or an external fetch holds the bus: wait it out
            if (conflict_in)
               next_state = ST_MAIN;
            else if (needs_sync && !sel_tick)
               next_state = ST_SYNC;
            else
               next_state = ST_PERI;
         end
         ST_SYNC:
         begin
            // the first target edge ends main plus sync within one target cycle
            if (sel_tick)
               next_state = ST_PERI;
         end
         ST_PERI:
         begin
            if (peri_tick)
            begin
               next_remain = remain - 4'h1;
               if (remain == 4'h1)
                  next_state = ST_DONE;
            end
         end
         ST_DONE:
         begin
            // answer cycle; a request standing now is taken without an idle gap
            if (take)
            begin
               next_state  = ST_MAIN;
               next_remain = load_cycles;
            end
            else
               next_state = ST_IDLE;
         end
         default:
         begin
            next_state  = ST_IDLE;
            next_remain = 4'h0;
         end
      endcase
   end

   // state and counter
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         state  <= ST_IDLE;
         remain <= 4'h0;
      end
      else
      begin
         state  <= next_state;
         remain <= next_remain;
      end
   end

   // capture the request so the master may change its pins while stalled
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         held <= '0;
      else if (take)
         held <= req_in;
   end

   // master handshake: stall while busy, one cycle acknowledge with read data
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         stall_out <= 1'b0;
         ack_out   <= 1'b0;
         rdata_out <= `RESET_DATA;
      end
      else
      begin
         stall_out <= (next_state != ST_IDLE) && (next_state != ST_DONE);
         ack_out   <= (next_state == ST_DONE);
         // read data is sampled on the last peripheral cycle; writes return zero
         if (state == ST_PERI && next_state == ST_DONE)
            rdata_out <= held.write ? `RESET_DATA : per_rdata_in;
      end
   end

   // peripheral request stands through every peripheral bus cycle
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         per_req_out <= '0;
      else
      begin
         per_req_out.valid   <= (next_state == ST_PERI);
         per_req_out.write   <= held.write;
         per_req_out.addr    <= held.addr;
         per_req_out.wdata   <= held.wdata;
         per_req_out.size    <= held.size;
         per_req_out.bus_num <= held.bus_num;
      end
   end

endmodule

//--- hdl/bridge_map.svh
// constants of the peripheral bus bridge: bus numbers, cycle counts, decode window
`ifndef BRIDGE_MAP_SVH
`define BRIDGE_MAP_SVH

// main bus cycles spent before the peripheral side is reached
`define MAIN_BUS_CYCLES     4'h1
// peripheral bus number that needs no divided clock synchronization
`define SYNC_FREE_BUS       3'h1
// highest internal peripheral bus number
`define LAST_PERIPH_BUS     3'h6
// bus number that routes to the external bus control unit
`define EXT_BUS             3'h7
// pin function select register window, byte wide, fixed bus cycle count
`define PIN_FUNC_LOW        32'h0008_C100
`define PIN_FUNC_HIGH       32'h0008_C1FF
`define PIN_FUNC_CYCLES     4'h2
// reset values
`define RESET_DATA          32'h0000_0000
`define RESET_DIV           4'h0

`endif

//--- hdl/bridge_pkg.sv
// types shared by the peripheral bus bridge and its testbench
package bridge_pkg;

   // access size on the main bus
   typedef enum logic [1:0] {
      SIZE_BYTE = 2'h0,
      SIZE_WORD = 2'h1,
      SIZE_LONG = 2'h2
   } access_size_type;

   // which divided clock the target runs on
   typedef enum logic [1:0] {
      TGT_PERIPH = 2'h0,
      TGT_FLASH  = 2'h1,
      TGT_EXTBUS = 2'h2
   } target_clk_type;

   // request from the bus master
   typedef struct packed {
      logic            valid;
      logic            write;
      logic [31:0]     addr;
      logic [31:0]     wdata;
      access_size_type size;
      logic [2:0]      bus_num;
      target_clk_type  tgt_clk;
      logic [3:0]      bus_cycles;
   } master_req_type;

   // request toward the peripheral register files
   typedef struct packed {
      logic            valid;
      logic            write;
      logic [31:0]     addr;
      logic [31:0]     wdata;
      access_size_type size;
      logic [2:0]      bus_num;
   } periph_req_type;

   // bridge sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_MAIN = 5'b00010,
      ST_SYNC = 5'b00100,
      ST_PERI = 5'b01000,
      ST_DONE = 5'b10000
   } bridge_state_type;

endpackage

//--- hdl/clock_phase_tick.sv
// one cycle tick marking each edge of a divided clock, seen from the core clock
`timescale 1ns/1ns
module clock_phase_tick #(
   parameter int DIV_W = 4
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             arst_n_in,
   // ratio of core clock to target clock; 0 means the target is faster
   input  wire logic [DIV_W-1:0] div_in,
   // tick in the core cycle that holds a target clock edge
   output logic                  tick_out
);

   logic [DIV_W-1:0] phase;       // core cycles since the last target edge
   logic [DIV_W-1:0] next_phase;  // phase after this cycle
   wire              wrap;        // last core cycle of a target period
   wire              every_cycle; // target as fast as the core or faster

   assign every_cycle = (div_in <= {{(DIV_W-1){1'b0}}, 1'b1});
   assign wrap        = every_cycle || (phase >= div_in - {{(DIV_W-1){1'b0}}, 1'b1});
   assign next_phase  = wrap ? '0 : phase + {{(DIV_W-1){1'b0}}, 1'b1};

   // free running phase counter; a ratio change keeps the count, which wraps at once if already past the new period
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         phase    <= '0;
         tick_out <= 1'b0;
      end
      else
      begin
         phase    <= next_phase;
         tick_out <= wrap;
      end
   end

endmodule

//--- tb/bridge_checker.sv
// port level assertions for the peripheral bus bridge
`timescale 1ns/1ns
`include "bridge_map.svh"
module bridge_checker #(
   parameter int DIV_W = 4
) (
   // clock and reset
   input wire logic                       clk_in,
   input wire logic                       arst_n_in,
   // divided clock ratios
   input wire logic [DIV_W-1:0]           periph_div_in,
   input wire logic [DIV_W-1:0]           flash_div_in,
   input wire logic [DIV_W-1:0]           extbus_div_in,
   // master side
   input wire bridge_pkg::master_req_type req_in,
   input wire logic                       conflict_in,
   input wire logic                       stall_out,
   input wire logic                       ack_out,
   input wire logic [31:0]                rdata_out,
   // peripheral side
   input wire bridge_pkg::periph_req_type per_req_out,
   input wire logic [31:0]                per_rdata_in
);
   import bridge_pkg::*;
   // generous bound on main cycle plus one wait for a target edge
   localparam int SYNC_MAX = 17;
   // ratio of the clock the request is aimed at
   wire logic [DIV_W-1:0] sel_div = (req_in.bus_num == `EXT_BUS || req_in.tgt_clk == TGT_EXTBUS)
      ? extbus_div_in : (req_in.tgt_clk == TGT_FLASH) ? flash_div_in : periph_div_in;
   wire logic take = req_in.valid && !stall_out;   // request accepted at this edge
   wire logic fast = take && sel_div < 2;           // target no slower than core
   wire logic pin  = req_in.addr >= `PIN_FUNC_LOW && req_in.addr <= `PIN_FUNC_HIGH
      && req_in.size == SIZE_BYTE;                  // pin function byte access
   wire logic slow = take && sel_div > 1 && req_in.bus_num != `SYNC_FREE_BUS;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   take_stall_a: assert property (take |=> stall_out) else $error("no stall after take");
   one_cycle_a: assert property ((fast && req_in.bus_cycles == 4'h1 && !pin) ##1 !conflict_in
      |=> per_req_out.valid ##1 (ack_out && !per_req_out.valid)) else $error("one cycle access");
   two_cycle_a: assert property ((fast && req_in.bus_cycles == 4'h2 && !pin) ##1 !conflict_in
      |=> per_req_out.valid [*2] ##1 ack_out) else $error("two cycle access");
   pin_byte_a: assert property ((fast && pin) ##1 !conflict_in
      |=> per_req_out.valid [*2] ##1 ack_out) else $error("pin byte access length");
   bus_one_a: assert property ((take && req_in.bus_num == `SYNC_FREE_BUS) ##1 !conflict_in
      |=> per_req_out.valid) else $error("sync on bus one");
   sync_bound_a: assert property (slow ##1 !conflict_in
      |-> ##[1:SYNC_MAX] per_req_out.valid) else $error("sync too long");
   ext_bound_a: assert property ((take && req_in.bus_num == `EXT_BUS) ##1 !conflict_in
      |-> ##[1:SYNC_MAX] per_req_out.valid) else $error("external sync too long");
   conflict_hold_a: assert property (take ##1 conflict_in |=> !per_req_out.valid)
      else $error("conflict not waited");
   read_data_a: assert property (ack_out && !$past(per_req_out.write)
      |-> rdata_out == $past(per_rdata_in)) else $error("read data lost");
   write_zero_a: assert property (ack_out && $past(per_req_out.write)
      |-> rdata_out == `RESET_DATA) else $error("write returned data");
   ack_pulse_a: assert property (ack_out |-> !stall_out ##1 !ack_out)
      else $error("ack not a pulse");
   next_take_a: assert property (ack_out && req_in.valid |=> stall_out)
      else $error("next access not started");
   fields_copy_a: assert property (take |-> ##2
      (per_req_out.bus_num == $past(req_in.bus_num, 2)
      && per_req_out.size == $past(req_in.size, 2))) else $error("request fields lost");
   sync_half_a: assert property ((slow && sel_div == 2) ##1 !conflict_in
      |-> ##[1:2] per_req_out.valid) else $error("sync over one target cycle");
endmodule

bind peripheral_bus_bridge bridge_checker #(.DIV_W(DIV_W)) chk (.clk_in, .arst_n_in,
   .periph_div_in, .flash_div_in, .extbus_div_in, .req_in, .conflict_in, .stall_out,
   .ack_out, .rdata_out, .per_req_out, .per_rdata_in);

//--- tb/periph_model.sv
// peripheral register file model behind the bridge
`timescale 1ns/1ns
module periph_model (
   // clock
   input  wire logic                       clk_in,
   // request from the bridge
   input  wire bridge_pkg::periph_req_type per_req_in,
   // read data toward the bridge
   output logic [31:0]                     per_rdata_out
);
   import bridge_pkg::*;
   logic [31:0] regs [16];   // word registers picked by address bits 5..2
   initial
   begin
      foreach (regs[i]) regs[i] = 32'h0;
   end
   // writes land on every cycle of the peripheral phase
   always @(posedge clk_in)
   begin
      if (per_req_in.valid && per_req_in.write)
         regs[per_req_in.addr[5:2]] <= per_req_in.wdata;
   end
   // an idle bus shows the inverse, so a late sample cannot pass for data
   assign per_rdata_out = (per_req_in.valid && !per_req_in.write)
      ? regs[per_req_in.addr[5:2]] : ~regs[per_req_in.addr[5:2]];
endmodule

//--- tb/tb_top.sv
// self-checking bench for the peripheral bus bridge
`timescale 1ns/1ns
`include "bridge_map.svh"
module tb_top;
   import bridge_pkg::*;
   typedef struct {logic [31:0] data; int lo; int hi;} note_type;
   logic           clk_in, arst_n_in, conflict_in, stall_out, ack_out;
   logic [3:0]     periph_div_in, flash_div_in, extbus_div_in;
   logic [31:0]    rdata_out, per_rdata_in, a, d;
   master_req_type req_in;
   periph_req_type per_req_out;
   note_type       notes [$];       // expected results, oldest first
   logic [31:0]    shadow [16];     // what the registers should hold
   logic [31:0]    seed = 32'h50B09E90;
   int             fails, checks_done, lat, cycles;

   peripheral_bus_bridge #(.DIV_W(4)) dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
      .periph_div_in(periph_div_in), .flash_div_in(flash_div_in),
      .extbus_div_in(extbus_div_in), .req_in(req_in), .conflict_in(conflict_in),
      .stall_out(stall_out), .ack_out(ack_out), .rdata_out(rdata_out),
      .per_req_out(per_req_out), .per_rdata_in(per_rdata_in));
   periph_model regs_i (.clk_in(clk_in), .per_req_in(per_req_out),
      .per_rdata_out(per_rdata_in));

   initial
   begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic do_reset();
      arst_n_in <= 1'b0;
      repeat (20) @(posedge clk_in);
      arst_n_in <= 1'b1;
   endtask

   // one access held until taken; c cycles of bus conflict follow the take
   task automatic access(logic wr, logic [31:0] adr, access_size_type sz, logic [2:0] bus,
                         target_clk_type tc, logic [3:0] n, int c);
      note_type   nt;
      logic [3:0] dv;
      logic [31:0] wd;
      int         k;
      @(posedge clk_in);
      dv = (bus == 3'h7 || tc == TGT_EXTBUS) ? extbus_div_in
         : (tc == TGT_FLASH) ? flash_div_in : periph_div_in;
      k = (adr >= `PIN_FUNC_LOW && adr <= `PIN_FUNC_HIGH && sz == SIZE_BYTE) ? 2
         : (n == 4'h0) ? 1 : int'(n);
      wd = rnd();
      nt.data = wr ? 32'h0 : shadow[adr[5:2]];
      nt.lo = 2 + k + ((dv < 2 && c > 0) ? 1 : 0);
      nt.hi = (dv < 2) ? 2 + k + c : 3 + int'(dv) * (k + 2) + c;
      if (wr)
         shadow[adr[5:2]] = wd;
      notes.push_back(nt);
      req_in <= '{1'b1, wr, adr, wd, sz, bus, tc, n};
      do @(posedge clk_in); while (stall_out !== 1'b0);
      req_in.valid <= 1'b0;
      if (c > 0)
      begin
         conflict_in <= 1'b1;
         repeat (c) @(posedge clk_in);
         conflict_in <= 1'b0;
      end
   endtask

   // watcher: time each access from its take and compare at its ack
   always @(posedge clk_in)
   begin
      note_type nt;
      lat = lat + 1;
      if (ack_out === 1'b1)
      begin
         check("note waiting", 32'(notes.size() > 0), 32'h1);
         nt = notes.pop_front();
         check("read data", rdata_out, nt.data);
         check("latency", 32'(lat >= nt.lo && lat <= nt.hi), 32'h1);
      end
      if (req_in.valid === 1'b1 && stall_out === 1'b0)
         lat = 0;
   end

   // a hang is cut short and counted
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         finish_test();
      end
   end

   initial
   begin
      arst_n_in = 1'b0;
      conflict_in = 1'b0;
      req_in = '0;
      {periph_div_in, flash_div_in, extbus_div_in} = '0;
      foreach (shadow[i]) shadow[i] = 32'h0;
      do_reset();
      // write then read back only that register; system registers are never written
      for (int r = 0; r < 36; r++)
      begin
         while (notes.size() != 0) @(posedge clk_in);
         d = (r < 12) ? 32'h0 : rnd();
         {periph_div_in, flash_div_in, extbus_div_in} <= {2'h0, d[1:0], 2'h0, d[5:4], 2'h0, d[9:8]};
         a = `PIN_FUNC_LOW + (rnd() & 32'h3C) + ((r % 2 == 1) ? 32'h0 : 32'h100);
         access(1'b1, a, SIZE_LONG, (r % 4 == 0) ? 3'h1 : (r % 4 == 3) ? 3'h7 : 3'(2 + r % 5),
                target_clk_type'(r % 3), 4'(r % 4), r % 3);
         access(1'b0, a, access_size_type'(r % 3), (r % 4 == 0) ? 3'h1 : (r % 4 == 3) ? 3'h7
                : 3'(2 + r % 5), target_clk_type'(r / 3 % 3), 4'(r % 5), 0);
      end
      while (notes.size() != 0) @(posedge clk_in);
      // reset lands on the edge that takes an access
      access(1'b1, 32'h0008C204, SIZE_LONG, 3'h2, TGT_PERIPH, 4'h3, 0);
      do_reset();
      notes.delete();
      @(posedge clk_in);
      check("stall after reset", stall_out, 32'h0);
      check("ack after reset", ack_out, 32'h0);
      check("valid after reset", per_req_out.valid, 32'h0);
      access(1'b0, `PIN_FUNC_LOW + 32'h8, SIZE_BYTE, 3'h1, TGT_PERIPH, 4'h1, 0);
      while (notes.size() != 0) @(posedge clk_in);
      finish_test();
   end
endmodule
